//--- sim/radio_readout_model.sv
// Far-side stand-in: radio receiver pulses and a tally of forwarded counts
// Assumes the bench calls send() and all timing is on ref_clk
module radio_readout_model (
  input  wire logic ref_clk,
  input  wire logic counter_pulse,
  output logic      radio_pulse,
  output int        tally
);
  timeunit 1ns;
  timeprecision 1ps;
  initial radio_pulse = 1'b0;
  initial tally = 0;
  // Tally every pulse that reaches the readout input
  always @(posedge ref_clk) begin
    if (counter_pulse === 1'b1) tally <= tally + 1;
  end
  // Three-cycle radio pulse, then back low
  task automatic send();
    @(posedge ref_clk);
    radio_pulse <= 1'b1;
    repeat (3) @(posedge ref_clk);
    radio_pulse <= 1'b0;
  endtask
endmodule

//--- sim/time_interval_gate_divider_test.sv
// Self-checking bench for the interval gate unit
// Assumes radio_readout_model as the far side and a short one-shot
module time_interval_gate_divider_test;
  timeunit 1ns;
  timeprecision 1ps;
  import interval_gate_pkg::*;
  localparam int unsigned OS = 8;
  logic ref_clk = 1'b0, arst_n = 1'b0, ref_pulse = 1'b0, relay_pulse = 1'b0;
  logic interval_sel = 1'b0, clear = 1'b0, radio_pulse;
  logic half_rate_first, half_rate_first_n, half_rate_second, half_rate_second_n;
  logic light_gate_drive, counter_pulse, gate_open, indicator_trigger;
  decade_type units_digit, tens_digit;
  int n_errors = 0, n_checks = 0, tally, t0, ind_len = 0;
  logic h;
  // Rows: select, pulses gated, expected tens and units
  int rows[4][3] = '{'{0, 3, 'h03}, '{1, 12, 'h12}, '{0, 0, 'h00}, '{1, 105, 'h05}};
  interval_gate_unit #(.ONESHOT_LEN(OS)) uut (.ref_clk, .arst_n, .ref_pulse, .relay_pulse,
    .radio_pulse, .interval_sel, .clear, .half_rate_first, .half_rate_first_n,
    .half_rate_second, .half_rate_second_n, .light_gate_drive, .counter_pulse,
    .gate_open, .indicator_trigger, .units_digit, .tens_digit);
  radio_readout_model m (.ref_clk, .counter_pulse, .radio_pulse, .tally);
  // Clock and indicator length meter
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (indicator_trigger === 1'b1) ind_len <= ind_len + 1;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    if (n_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // 0 reference, 1 relay, 2 clear, 3 radio; then settle
  task automatic fire(input int w);
    if (w == 3) m.send();
    else begin
      @(posedge ref_clk);
      case (w)
        0: ref_pulse <= 1'b1;
        1: relay_pulse <= 1'b1;
        default: clear <= 1'b1;
      endcase
      repeat (2) @(posedge ref_clk);
      {ref_pulse, relay_pulse, clear} <= 3'b000;
    end
    repeat (5) @(posedge ref_clk);
  endtask
  task automatic measure(input logic sel, input int n);
    @(posedge ref_clk);
    interval_sel <= sel;
    fire(2);
    fire(sel ? 3 : 1);
    check({7'h00, gate_open}, 8'h01);
    repeat (n) fire(0);
    fire(sel ? 1 : 3);
    fire(0);
  endtask
  initial begin
    repeat (100000) @(posedge ref_clk);
    n_errors++;
    wrap_up();
  end
  // Reset values, table of measurements, then awkward cases
  initial begin
    repeat (10) @(posedge ref_clk);
    check({half_rate_first, half_rate_first_n, half_rate_second, half_rate_second_n,
      light_gate_drive, counter_pulse, gate_open, indicator_trigger}, 8'h50);
    arst_n <= 1'b1;
    h = half_rate_first;
    fire(0);
    check({3'h0, half_rate_first, half_rate_first_n, half_rate_second, half_rate_second_n,
      light_gate_drive}, {3'h0, ~h, h, ~h, h, ~h});
    foreach (rows[i]) begin
      t0 = tally;
      measure(rows[i][0][0], rows[i][1]);
      check({tens_digit, units_digit}, 8'(rows[i][2]));
      check(8'(tally - t0), 8'(rows[i][1]));
      check({7'h00, gate_open}, 8'h00);
    end
    interval_sel <= 1'b0;
    fire(2);
    ind_len = 0;
    fire(3);
    repeat (20) @(posedge ref_clk);
    check(8'(ind_len), 8'(OS));
    check({7'h00, gate_open}, 8'h00);
    fire(1);
    fire(0);
    fire(2);
    t0 = tally;
    fire(0);
    check({tens_digit, units_digit}, 8'h00);
    check({7'h00, gate_open}, 8'h00);
    check(8'(tally - t0), 8'h00);
    wrap_up();
  end
endmodule

//--- src/decade_counter.sv
// One decade stage of the readout counter
// Assumes count enable is a single-cycle pulse in the ref_clk domain
`include "interval_gate_defs.svh"
module decade_counter (
  input  wire logic                        ref_clk,
  input  wire logic                        arst_n,
  input  wire logic                        clear,
  input  wire logic                        step,
  output interval_gate_pkg::decade_type    digit,
  output logic                             carry
);
  import interval_gate_pkg::*;
  decade_type digit_reg;
  // Wraps from nine to zero and flags the carry in that cycle
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      digit_reg <= 4'h0;
    end else if (clear) begin
      digit_reg <= 4'h0;
    end else if (step) begin
      digit_reg <= (digit_reg == `DECADE_LAST) ? 4'h0 : digit_reg + 4'h1;
    end
  end
  assign digit = digit_reg;
  assign carry = step && (digit_reg == `DECADE_LAST);
endmodule

//--- src/interval_gate_defs.svh
// Timing constants and encodings for the interval gate block
// Assumes a single 200 MHz reference clock and no software registers
//
// What this block does
// - Divider toggles per reference pulse, giving complementary half-rate square waves.
// - Second half-rate divider output also gates the light-gate time marking.
// - Relay-to-radio select: relay pulse starts, radio pulse stops the gate.
// - Radio-to-relay select: radio pulse starts, following relay pulse stops.
// - Clear forces start and stop flip-flops idle, gate closed.
// - Start event sets start flip-flop, releases stop block, opens gate.
// - While open, each reference pulse not coinciding with the stop event or clear is passed to the readout counter.
// - Stop event re-blocks the gate until the next clear and start.
// - Each forwarded pulse counts 10 ms of the interval.
// - Radio pulse fires a one-shot feeding the indicator trigger; the select path takes the radio edge directly.
// - Indicator flashes for 100 ms after each radio pulse, from the radio one-shot.
// - Readout is two cascaded decades; one hundred pulses make a full cycle.
// - Relay event is the relay_pulse input, synchronised and edge-detected, routed through the select.
`ifndef INTERVAL_GATE_DEFS_SVH
`define INTERVAL_GATE_DEFS_SVH
`define CLK_PERIOD_NS      5
`define ONESHOT_TIME_NS    100000000
`define ONESHOT_CYCLES     (`ONESHOT_TIME_NS / `CLK_PERIOD_NS)
`define TICK_MS            10
`define DECADE_LAST        4'h9
`define SEL_RELAY_FIRST    1'b0
`define SEL_RADIO_FIRST    1'b1
`endif

//--- src/interval_gate_pkg.sv
// Types for the interval gate block
// Assumes interval_gate_defs.svh supplies the numeric constants
package interval_gate_pkg;
  typedef enum logic [1:0] {
    GATE_IDLE   = 2'b00,
    GATE_OPEN   = 2'b01,
    GATE_CLOSED = 2'b11
  } gate_state_type;
  typedef logic [3:0] decade_type;
endpackage

//--- src/interval_gate_unit.sv
// Interval gate: half-rate dividers, start/stop gate, radio one-shot, readout
// Assumes all inputs are synchronous to ref_clk and pulses last at least one cycle
`include "interval_gate_defs.svh"
module interval_gate_unit #(
  parameter int unsigned ONESHOT_LEN = `ONESHOT_CYCLES
) (
  input  wire logic                        ref_clk,
  input  wire logic                        arst_n,
  input  wire logic                        ref_pulse,
  input  wire logic                        relay_pulse,
  input  wire logic                        radio_pulse,
  input  wire logic                        interval_sel,
  input  wire logic                        clear,
  output logic                             half_rate_first,
  output logic                             half_rate_first_n,
  output logic                             half_rate_second,
  output logic                             half_rate_second_n,
  output logic                             light_gate_drive,
  output logic                             counter_pulse,
  output logic                             gate_open,
  output logic                             indicator_trigger,
  output interval_gate_pkg::decade_type    units_digit,
  output interval_gate_pkg::decade_type    tens_digit
);
  import interval_gate_pkg::*;

  logic [1:0]     divider_reg;
  logic [2:0]     ref_sync_reg;
  logic [2:0]     relay_sync_reg;
  logic [2:0]     radio_sync_reg;
  logic           ref_evt;
  logic           relay_evt;
  logic           radio_evt;
  logic [31:0]    shot_cnt_reg;
  logic           shot_reg;
  logic           start_evt;
  logic           stop_evt;
  gate_state_type state_reg;
  logic           fwd_reg;
  logic           units_carry;
  logic           fwd_step;

  // Two-stage synchronisers plus edge detect on the third stage
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ref_sync_reg   <= 3'h0;
      relay_sync_reg <= 3'h0;
      radio_sync_reg <= 3'h0;
    end else begin
      ref_sync_reg   <= {ref_sync_reg[1:0], ref_pulse};
      relay_sync_reg <= {relay_sync_reg[1:0], relay_pulse};
      radio_sync_reg <= {radio_sync_reg[1:0], radio_pulse};
    end
  end
  assign ref_evt   = ref_sync_reg[1] && !ref_sync_reg[2];
  assign relay_evt = relay_sync_reg[1] && !relay_sync_reg[2];
  assign radio_evt = radio_sync_reg[1] && !radio_sync_reg[2];

  // Both half-rate dividers toggle on every reference pulse
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      divider_reg <= 2'h0;
    end else if (ref_evt) begin
      divider_reg <= ~divider_reg;
    end
  end
  assign half_rate_first    = divider_reg[0];
  assign half_rate_first_n  = ~divider_reg[0];
  assign half_rate_second   = divider_reg[1];
  assign half_rate_second_n = ~divider_reg[1];
  assign light_gate_drive   = divider_reg[1];

  // Radio one-shot, retriggerable, drives the indicator flash
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      shot_cnt_reg <= 32'h0;
      shot_reg     <= 1'b0;
    end else if (radio_evt) begin
      shot_cnt_reg <= ONESHOT_LEN - 1;
      shot_reg     <= 1'b1;
    end else if (shot_cnt_reg != 32'h0) begin
      shot_cnt_reg <= shot_cnt_reg - 32'h1;
    end else begin
      shot_reg <= 1'b0;
    end
  end
  assign indicator_trigger = shot_reg;

  // Interval select routes relay and radio events to start and stop
  assign start_evt = (interval_sel == `SEL_RELAY_FIRST) ? relay_evt : radio_evt;
  assign stop_evt  = (interval_sel == `SEL_RELAY_FIRST) ? radio_evt : relay_evt;

  // Start/stop gate; clear wins and re-arms, stop after start is final
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= GATE_IDLE;
    end else if (clear) begin
      state_reg <= GATE_IDLE;
    end else begin
      case (state_reg)
        GATE_IDLE: begin
          if (start_evt) begin
            state_reg <= GATE_OPEN;
          end
        end
        GATE_OPEN: begin
          if (stop_evt) begin
            state_reg <= GATE_CLOSED;
          end
        end
        GATE_CLOSED: begin
          state_reg <= GATE_CLOSED;
        end
        default: begin
          state_reg <= GATE_IDLE;
        end
      endcase
    end
  end
  assign gate_open = (state_reg == GATE_OPEN);

  // Forward reference pulses while open, registered one cycle
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      fwd_reg <= 1'b0;
    end else begin
      fwd_reg <= ref_evt && gate_open && !stop_evt && !clear;
    end
  end
  assign counter_pulse = fwd_reg;
  assign fwd_step      = fwd_reg;

  // Two cascaded decades, cleared with the gate
  decade_counter units_stage (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .clear   (clear),
    .step    (fwd_step),
    .digit   (units_digit),
    .carry   (units_carry)
  );
  decade_counter tens_stage (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .clear   (clear),
    .step    (units_carry),
    .digit   (tens_digit),
    .carry   ()
  );

  sequence s_start_seen;
    !clear && state_reg == GATE_IDLE && start_evt;
  endsequence

  a_clear_closes: assert property (@(posedge ref_clk) disable iff (!arst_n)
    clear |=> !gate_open) else $error("gate open after clear");
  a_start_opens: assert property (@(posedge ref_clk) disable iff (!arst_n)
    s_start_seen |=> gate_open) else $error("start did not open gate");
  a_stop_closes: assert property (@(posedge ref_clk) disable iff (!arst_n)
    gate_open && stop_evt && !clear |=> !gate_open [*2]) else $error("stop failed");
  a_fwd_gated: assert property (@(posedge ref_clk) disable iff (!arst_n)
    counter_pulse |-> $past(gate_open) && $past(ref_evt)) else $error("stray pulse");
  a_fwd_passes: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ref_evt && gate_open && !stop_evt && !clear |=> counter_pulse)
    else $error("pulse dropped");
  a_divider_toggle: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ref_evt |=> half_rate_first != $past(half_rate_first)) else $error("no toggle");
  a_divider_compl: assert property (@(posedge ref_clk) disable iff (!arst_n)
    half_rate_second_n == !light_gate_drive) else $error("outputs not complementary");
  a_oneshot_fires: assert property (@(posedge ref_clk) disable iff (!arst_n)
    radio_evt |=> indicator_trigger [*2]) else $error("one-shot missed");
  a_select_routes: assert property (@(posedge ref_clk) disable iff (!arst_n)
    interval_sel == `SEL_RADIO_FIRST |-> start_evt == radio_evt)
    else $error("select misrouted");
  a_edge_single: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ref_evt |=> !ref_evt) else $error("event longer than one cycle");
  a_decade_wrap: assert property (@(posedge ref_clk) disable iff (!arst_n)
    units_carry && !clear |=> units_digit == 4'h0) else $error("decade wrap wrong");
endmodule
